/* File: core/dcr_pkg.sv */
// Shared constants, field positions, reset values and the state layout of the DAC register bank.
package dcr_pkg;

	// Register offsets.
	localparam logic [4:0] OFS_CODE_LIVE0 = 5'h00;
	localparam logic [4:0] OFS_REF_LIVE = 5'h08;
	localparam logic [4:0] OFS_PD_LIVE = 5'h09;
	localparam logic [4:0] OFS_GAIN_STATUS = 5'h0a;
	localparam logic [4:0] OFS_LOCK_STATUS = 5'h0b;
	localparam logic [4:0] OFS_CODE_STORED0 = 5'h10;
	localparam logic [4:0] OFS_REF_STORED = 5'h18;
	localparam logic [4:0] OFS_PD_STORED = 5'h19;
	localparam logic [4:0] OFS_GAIN_ADDR_STORED = 5'h1a;

	// Field positions.
	localparam int NV_SPACE_BIT = 4;
	localparam int POR_FLAG_BIT = 7;
	localparam int BUSY_FLAG_BIT = 6;
	localparam int ADDR_LOCK_BIT = 7;
	localparam int GAIN_LSB = 8;
	localparam int ADDR_UPPER_LSB = 2;

	// Reset values and fixed values.
	localparam logic [15:0] RESERVED_READ = 16'hffff;
	localparam logic [4:0] FIXED_ADDR_UPPER = 5'h18;
	localparam logic [4:0] RST_ADDR_UPPER = 5'h18;
	localparam logic RST_ADDRESS_LOCK = 1'b1;
	localparam logic RST_POR_FLAG = 1'b1;
	localparam logic [7:0] RST_LOCK_BITS = 8'h00;
	localparam logic [15:0] RST_REF = 16'h0000;
	localparam logic [15:0] RST_PD = 16'h0000;
	localparam logic [7:0] RST_GAIN = 8'h00;

	// Lock pair codes, stored-side bit first.
	localparam logic [1:0] LOCK_ALL = 2'h3;
	localparam logic [1:0] LOCK_EXCEPT_LIVE_CFG = 2'h2;
	localparam logic [1:0] LOCK_STORED_ONLY = 2'h1;
	localparam logic [1:0] LOCK_NONE = 2'h0;

	// Reference select codes.
	localparam logic [1:0] REF_PIN_BUFFERED = 2'h3;
	localparam logic [1:0] REF_PIN_UNBUFFERED = 2'h2;
	localparam logic [1:0] REF_BANDGAP = 2'h1;
	localparam logic [1:0] REF_SUPPLY = 2'h0;

	// Power-down codes.
	localparam logic [1:0] PD_OPEN = 2'h3;
	localparam logic [1:0] PD_LOAD_125K = 2'h2;
	localparam logic [1:0] PD_LOAD_1K = 2'h1;
	localparam logic [1:0] PD_NORMAL = 2'h0;

	// Stored-memory write cycle time and its length in clock cycles.
	localparam int NV_WRITE_TIME_NS = 25000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int NV_WRITE_CYCLES_DEF = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_W = 16;

	// Kind of location that a write aims at.
	typedef enum logic [1:0] {ACC_CODE_LIVE, ACC_CODE_STORED, ACC_CFG_LIVE, ACC_CFG_STORED} dcr_access_t;

	// Whole state of the register bank.
	typedef struct packed {
		logic [7:0][15:0] code_live;
		logic [7:0][15:0] code_stored;
		logic [15:0] ref_live;
		logic [15:0] ref_stored;
		logic [15:0] pd_live;
		logic [15:0] pd_stored;
		logic [7:0] gain_live;
		logic [7:0] gain_stored;
		logic [7:0] stored_side_lock_bit;
		logic [7:0] live_side_lock_bit;
		logic address_lock_config_bit;
		logic [4:0] slave_address_upper_five;
		logic por_flag;
		logic [BUSY_W-1:0] busy_cnt;
		logic eeprom_busy_flag;
		logic [15:0] rdata;
		logic ack;
		logic nack;
		logic vref_drive;
		logic [6:0] slave_address_field;
	} dcr_state_t;

endpackage

/* File: core/dcr_reg_bank.sv */
// Register bank of a quad or octal DAC: output codes, configuration, per-channel locks and status.
`timescale 1ns/10ps
// Notes on behaviour
// - Lock pair 11 refuses writes to both codes and both configuration copies.
// - Lock pair 10 refuses codes and stored configuration; live configuration stays writable.
// - Lock pair 01 allows live code and live configuration, refuses stored ones.
// - Lock pair 00 allows every code and configuration write of the channel.
// - Reference pair, power-down pair and gain bit are the locked configuration bits.
// - Lock status register shows each channel's lock pair at bits 2n+1:2n.
// - Lock status follows both lock bits of each channel, stored-side and live-side, which start cleared.
// - Codes are right-justified in 16 bits; bits above the width read zero.
// - All ones is full scale, mask shifted right once is mid scale, zero is zero.
// - Live and stored copies share one bit layout.
// - Reference pair: 11 buffered pin, 10 unbuffered pin, 01 bandgap, 00 supply.
// - A channel on bandgap keeps the reference driven even when powered down.
// - Power-down pair: 00 normal, 01 1k load, 10 125k load, 11 open.
// - Gain bit set doubles gain; gain bits sit at 15:8.
// - Reset flag at bit 7 sets on power events, clears on reading its register.
// - Busy flag at bit 6 high during stored writes; only live accesses accepted.
// - Address lock status at bit 7 of stored gain register mirrors the config bit.
// - Upper five address bits writable only while the address lock is clear.
// - Stored parts take upper address bits from storage; volatile parts fix 11000.
// - Two low address bits come from the address-select pins.
// - Lock bits change only with the high-voltage pin up and a matching command.
// - A power event copies stored registers to live ones; stored writes leave live alone.
// - Reserved addresses answer not-acknowledge and read all ones.
module dcr_reg_bank
	import dcr_pkg::*;
#(
	parameter int CHANNELS = 8,
	parameter int CODE_BITS = 12,
	parameter bit HAS_NV = 1'b1,
	parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DEF
) (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic [4:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic HV_ENABLE,
	input wire logic HV_DISABLE,
	input wire logic HIGH_VOLTAGE_COMMAND_PIN,
	input wire logic ADDRESS_SELECT_PIN_LOW,
	input wire logic ADDRESS_SELECT_PIN_HIGH,
	input wire logic POR_EVENT,
	output logic [15:0] REG_RDATA,
	output logic REG_ACK,
	output logic REG_NACK,
	output logic [127:0] CODE_OUT,
	output logic [15:0] REF_SELECT,
	output logic [15:0] POWERDOWN_SELECT,
	output logic [7:0] GAIN_OUT,
	output logic VREF_DRIVE,
	output logic EEPROM_BUSY_FLAG,
	output logic [6:0] SLAVE_ADDRESS
);

	// Parameter values that the logic cannot serve are refused at elaboration.
	if (!(CHANNELS == 4 || CHANNELS == 8)) begin
		$error("CHANNELS must be 4 or 8");
	end
	if (!(CODE_BITS == 8 || CODE_BITS == 10 || CODE_BITS == 12)) begin
		$error("CODE_BITS must be 8, 10 or 12");
	end
	if (NV_WRITE_CYCLES < 1 || NV_WRITE_CYCLES > 65535) begin
		$error("NV_WRITE_CYCLES out of range");
	end

	// Code width mask, mid scale and channel presence.
	localparam logic [15:0] CODE_MASK = 16'((17'h1 << CODE_BITS) - 17'h1);
	localparam logic [15:0] CODE_MID = CODE_MASK >> 1;
	localparam logic [7:0] PRESENT = (CHANNELS == 8) ? 8'hff : 8'h0f;
	localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(NV_WRITE_CYCLES);

	dcr_state_t r;
	dcr_state_t next_r;
	logic [7:0] ok;
	logic [15:0] pm;
	logic [15:0] pres_pm;
	logic [2:0] ch;
	logic mapped;
	logic nv_acc;

	// Whether a lock pair allows a given kind of write.
	function automatic logic lock_allows(input logic [1:0] pair, input dcr_access_t acc);
		case (acc)
			ACC_CODE_LIVE: return pair == LOCK_STORED_ONLY || pair == LOCK_NONE;
			ACC_CFG_LIVE: return pair != LOCK_ALL;
			ACC_CODE_STORED: return pair == LOCK_NONE;
			ACC_CFG_STORED: return pair == LOCK_NONE;
			default: return 1'b0;
		endcase
	endfunction

	// Per-channel permission vector for a kind of write; absent channels never pass.
	function automatic logic [7:0] chan_ok(input logic [7:0] dl, input logic [7:0] cl, input dcr_access_t acc);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 8; i++) begin
			v[i] = PRESENT[i] && lock_allows({dl[i], cl[i]}, acc);
		end
		return v;
	endfunction

	// Spreads a per-channel vector over two-bit fields.
	function automatic logic [15:0] pair_mask(input logic [7:0] v);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			m[2*i] = v[i];
			m[2*i+1] = v[i];
		end
		return m;
	endfunction

	// True for offsets that exist on this part.
	function automatic logic is_mapped(input logic [4:0] a);
		logic [3:0] low;
		low = a[3:0];
		if (low < 4'h8) begin
			return PRESENT[low[2:0]];
		end
		if (a[NV_SPACE_BIT]) begin
			return low <= OFS_GAIN_ADDR_STORED[3:0];
		end
		return low <= OFS_LOCK_STATUS[3:0];
	endfunction

	// Lock status word, one pair per channel.
	function automatic logic [15:0] lock_word(input logic [7:0] dl, input logic [7:0] cl);
		logic [15:0] w;
		w = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			w[2*i+1] = dl[i] & PRESENT[i];
			w[2*i] = cl[i] & PRESENT[i];
		end
		return w;
	endfunction

	// Any present channel fed from the bandgap keeps the reference up.
	function automatic logic bandgap_used(input logic [15:0] refsel);
		logic u;
		u = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (PRESENT[i] && refsel[2*i +: 2] == REF_BANDGAP) begin
				u = 1'b1;
			end
		end
		return u;
	endfunction

	assign ch = REG_ADDR[2:0];
	assign mapped = is_mapped(REG_ADDR);
	assign nv_acc = REG_ADDR[NV_SPACE_BIT];
	assign pres_pm = pair_mask(PRESENT);

	// Next-state logic: one access per cycle, write before read, power events last so they win.
	always_comb begin
		next_r = r;
		next_r.ack = 1'b0;
		next_r.nack = 1'b0;
		ok = 8'h00;
		pm = 16'h0000;
		if (r.busy_cnt != '0) begin
			next_r.busy_cnt = r.busy_cnt - BUSY_W'(1);
		end
		if (REG_WR || REG_RD) begin
			if (!mapped || (nv_acc && r.eeprom_busy_flag)) begin
				next_r.nack = 1'b1;
				if (!REG_WR) begin
					next_r.rdata = RESERVED_READ;
				end
			end else if (REG_WR) begin
				next_r.ack = 1'b1;
				case (REG_ADDR)
					OFS_REF_LIVE, OFS_PD_LIVE, OFS_REF_STORED, OFS_PD_STORED: begin
						// Only unlocked channels take new bits; a changed locked field is refused.
						ok = chan_ok(r.stored_side_lock_bit, r.live_side_lock_bit,
							nv_acc ? ACC_CFG_STORED : ACC_CFG_LIVE);
						pm = pair_mask(ok);
						case (REG_ADDR)
							OFS_REF_LIVE: next_r.ref_live = (r.ref_live & ~pm) | (REG_WDATA & pm);
							OFS_PD_LIVE: next_r.pd_live = (r.pd_live & ~pm) | (REG_WDATA & pm);
							OFS_REF_STORED: next_r.ref_stored = (r.ref_stored & ~pm) | (REG_WDATA & pm);
							default: next_r.pd_stored = (r.pd_stored & ~pm) | (REG_WDATA & pm);
						endcase
						if (((REG_WDATA ^ (REG_ADDR[0] ? (nv_acc ? r.pd_stored : r.pd_live)
							: (nv_acc ? r.ref_stored : r.ref_live))) & pres_pm & ~pm) != 16'h0000) begin
							next_r.ack = 1'b0;
							next_r.nack = 1'b1;
						end
					end
					OFS_GAIN_STATUS, OFS_GAIN_ADDR_STORED: begin
						// Gain bits follow the configuration locks; status bits are not writable.
						ok = chan_ok(r.stored_side_lock_bit, r.live_side_lock_bit,
							nv_acc ? ACC_CFG_STORED : ACC_CFG_LIVE);
						if (nv_acc) begin
							next_r.gain_stored = (r.gain_stored & ~ok) | (REG_WDATA[15:GAIN_LSB] & ok);
							if (((REG_WDATA[15:GAIN_LSB] ^ r.gain_stored) & PRESENT & ~ok) != 8'h00) begin
								next_r.nack = 1'b1;
							end
							if (HAS_NV && !r.address_lock_config_bit) begin
								next_r.slave_address_upper_five = REG_WDATA[6:ADDR_UPPER_LSB];
							end else if (REG_WDATA[6:ADDR_UPPER_LSB] != r.slave_address_upper_five) begin
								next_r.nack = 1'b1;
							end
						end else begin
							next_r.gain_live = (r.gain_live & ~ok) | (REG_WDATA[15:GAIN_LSB] & ok);
							if (((REG_WDATA[15:GAIN_LSB] ^ r.gain_live) & PRESENT & ~ok) != 8'h00) begin
								next_r.nack = 1'b1;
							end
						end
						next_r.ack = !next_r.nack;
					end
					OFS_LOCK_STATUS: begin
						// Read-only; the write is taken and has no effect.
						next_r.ack = 1'b1;
					end
					default: begin
						// Output codes: only the implemented width is kept.
						if (lock_allows({r.stored_side_lock_bit[ch], r.live_side_lock_bit[ch]},
							nv_acc ? ACC_CODE_STORED : ACC_CODE_LIVE)) begin
							if (nv_acc) begin
								next_r.code_stored[ch] = REG_WDATA & CODE_MASK;
							end else begin
								next_r.code_live[ch] = REG_WDATA & CODE_MASK;
							end
						end else begin
							next_r.ack = 1'b0;
							next_r.nack = 1'b1;
						end
					end
				endcase
				// An accepted stored write starts the memory write cycle.
				if (nv_acc && next_r.ack) begin
					next_r.busy_cnt = BUSY_LOAD;
				end
			end else begin
				next_r.ack = 1'b1;
				case (REG_ADDR)
					OFS_REF_LIVE: next_r.rdata = r.ref_live & pres_pm;
					OFS_PD_LIVE: next_r.rdata = r.pd_live & pres_pm;
					OFS_REF_STORED: next_r.rdata = r.ref_stored & pres_pm;
					OFS_PD_STORED: next_r.rdata = r.pd_stored & pres_pm;
					OFS_GAIN_STATUS: begin
						next_r.rdata = {r.gain_live & PRESENT, r.por_flag, r.eeprom_busy_flag, 6'h00};
						next_r.por_flag = 1'b0;
					end
					OFS_LOCK_STATUS: next_r.rdata = lock_word(r.stored_side_lock_bit, r.live_side_lock_bit);
					OFS_GAIN_ADDR_STORED: next_r.rdata = {r.gain_stored & PRESENT, r.address_lock_config_bit,
						r.slave_address_field};
					default: next_r.rdata = nv_acc ? r.code_stored[ch] : r.code_live[ch];
				endcase
			end
		end else if (HV_ENABLE || HV_DISABLE) begin
			// Lock bits move only under the raised high-voltage pin and a matching address.
			if (!HIGH_VOLTAGE_COMMAND_PIN || r.eeprom_busy_flag) begin
				next_r.nack = 1'b1;
			end else if (REG_ADDR[3] == 1'b0 && PRESENT[ch]) begin
				next_r.ack = 1'b1;
				if (nv_acc) begin
					next_r.stored_side_lock_bit[ch] = HV_ENABLE;
				end else begin
					next_r.live_side_lock_bit[ch] = HV_ENABLE;
				end
			end else if (REG_ADDR == OFS_GAIN_ADDR_STORED) begin
				next_r.ack = 1'b1;
				next_r.address_lock_config_bit = HV_ENABLE;
			end else begin
				next_r.nack = 1'b1;
			end
		end
		// A power event reloads the live copies and sets the flag, winning over a read clear.
		if (POR_EVENT) begin
			next_r.code_live = r.code_stored;
			next_r.ref_live = r.ref_stored;
			next_r.pd_live = r.pd_stored;
			next_r.gain_live = r.gain_stored;
			next_r.por_flag = 1'b1;
		end
		next_r.eeprom_busy_flag = next_r.busy_cnt != '0;
		next_r.vref_drive = bandgap_used(next_r.ref_live);
		next_r.slave_address_field = {HAS_NV ? next_r.slave_address_upper_five : FIXED_ADDR_UPPER,
			ADDRESS_SELECT_PIN_HIGH, ADDRESS_SELECT_PIN_LOW};
	end

	// State register; reset loads the factory image with all channel locks open.
	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			r <= '0;
			for (int i = 0; i < 8; i++) begin
				r.code_live[i] <= PRESENT[i] ? ((i < 2) ? CODE_MID : CODE_MASK) : 16'h0000;
				r.code_stored[i] <= PRESENT[i] ? ((i < 2) ? CODE_MID : CODE_MASK) : 16'h0000;
			end
			r.ref_live <= RST_REF;
			r.ref_stored <= RST_REF;
			r.pd_live <= RST_PD;
			r.pd_stored <= RST_PD;
			r.gain_live <= RST_GAIN;
			r.gain_stored <= RST_GAIN;
			r.stored_side_lock_bit <= RST_LOCK_BITS;
			r.live_side_lock_bit <= RST_LOCK_BITS;
			r.address_lock_config_bit <= RST_ADDRESS_LOCK;
			r.slave_address_upper_five <= RST_ADDR_UPPER;
			r.por_flag <= RST_POR_FLAG;
		end else begin
			r <= next_r;
		end
	end

	// Every output is a field of the state register.
	assign REG_RDATA = r.rdata;
	assign REG_ACK = r.ack;
	assign REG_NACK = r.nack;
	assign CODE_OUT = r.code_live;
	assign REF_SELECT = r.ref_live;
	assign POWERDOWN_SELECT = r.pd_live;
	assign GAIN_OUT = r.gain_live;
	assign VREF_DRIVE = r.vref_drive;
	assign EEPROM_BUSY_FLAG = r.eeprom_busy_flag;
	assign SLAVE_ADDRESS = r.slave_address_field;

	// Checks on the register behaviour.
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESETN);

	a_live_code_lock: assert property (
		REG_WR && !REG_ADDR[4] && !REG_ADDR[3] && PRESENT[REG_ADDR[2:0]] && r.stored_side_lock_bit[REG_ADDR[2:0]]
		&& !POR_EVENT |=> REG_NACK && $stable(r.code_live))
		else $error("live code changed under lock");
	a_stored_code_lock: assert property (
		REG_WR && REG_ADDR[4] && !REG_ADDR[3] && PRESENT[REG_ADDR[2:0]] && !r.eeprom_busy_flag
		&& (r.live_side_lock_bit[REG_ADDR[2:0]] || r.stored_side_lock_bit[REG_ADDR[2:0]])
		|=> REG_NACK && !REG_ACK && $stable(r.code_stored))
		else $error("stored code write not refused");
	a_open_code_write: assert property (
		REG_WR && REG_ADDR[4:3] == 2'b00 && PRESENT[REG_ADDR[2:0]] && !POR_EVENT
		&& {r.stored_side_lock_bit[REG_ADDR[2:0]], r.live_side_lock_bit[REG_ADDR[2:0]]} == LOCK_NONE
		|=> REG_ACK && r.code_live[$past(REG_ADDR[2:0])] == ($past(REG_WDATA) & CODE_MASK))
		else $error("open live code write lost");
	a_reserved_read: assert property (
		REG_RD && !REG_WR && !is_mapped(REG_ADDR) |=> REG_NACK && REG_RDATA == RESERVED_READ)
		else $error("reserved read not refused");
	a_flag_read_clear: assert property (
		REG_RD && !REG_WR && REG_ADDR == OFS_GAIN_STATUS && !POR_EVENT
		|=> REG_ACK && !r.por_flag && REG_RDATA[POR_FLAG_BIT] == $past(r.por_flag))
		else $error("reset flag not cleared by its read");
	a_power_reload: assert property (
		POR_EVENT |=> r.por_flag && r.code_live == $past(r.code_stored) && r.ref_live == $past(r.ref_stored))
		else $error("power event did not reload");
	a_busy_refuse: assert property (
		(REG_WR || REG_RD) && REG_ADDR[4] && r.eeprom_busy_flag |=> REG_NACK && !REG_ACK)
		else $error("stored access taken while busy");
	a_busy_length: assert property (
		$rose(r.eeprom_busy_flag) |-> r.busy_cnt == BUSY_LOAD)
		else $error("busy cycle length wrong");
	a_addr_lock_hold: assert property (
		REG_WR && REG_ADDR == OFS_GAIN_ADDR_STORED && r.address_lock_config_bit |=> $stable(r.slave_address_upper_five))
		else $error("locked address changed");
	a_lock_readback: assert property (
		REG_RD && !REG_WR && REG_ADDR == OFS_LOCK_STATUS
		|=> REG_ACK && REG_RDATA == lock_word($past(r.stored_side_lock_bit), $past(r.live_side_lock_bit)))
		else $error("lock status mismatch");
	a_hv_gate: assert property (
		!HIGH_VOLTAGE_COMMAND_PIN |=> $stable(r.stored_side_lock_bit) && $stable(r.live_side_lock_bit))
		else $error("lock bits moved without high voltage");

endmodule

/* File: tb/dcr_host.sv */
// Host model that issues register, lock and high-voltage commands to the bank.
`timescale 1ns/10ps
module dcr_host (
	input wire logic MCLK,
	input wire logic EEPROM_BUSY_FLAG,
	input wire logic REG_ACK,
	input wire logic REG_NACK,
	input wire logic [15:0] REG_RDATA,
	output logic [4:0] REG_ADDR,
	output logic [15:0] REG_WDATA,
	output logic REG_WR,
	output logic REG_RD,
	output logic HV_ENABLE,
	output logic HV_DISABLE
);
	int late = 0;
	int stuck = 0;

	// Idle bus at time zero.
	initial begin
		REG_ADDR = 5'h1f;
		REG_WDATA = 16'h0000;
		{REG_WR, REG_RD, HV_ENABLE, HV_DISABLE} = 4'h0;
	end

	// Kind 0 write, 1 read, 2 set lock, 3 clear lock; bit 2 skips the busy wait.
	// Entered one step after a clock edge, so the strobe rises off the sampling edge.
	task automatic cmd(input logic [2:0] k, input logic [4:0] a, input logic [15:0] d,
		output logic [1:0] an, output logic [15:0] q);
		int n;
		n = 0;
		while (!k[2] && (a[4] || k[1]) && EEPROM_BUSY_FLAG !== 1'b0 && n < 64) begin
			@(posedge MCLK);
			#1;
			n++;
		end
		if (n == 64) begin
			stuck++;
		end
		repeat (late) @(posedge MCLK);
		REG_ADDR = a;
		REG_WDATA = d;
		{REG_WR, REG_RD, HV_ENABLE, HV_DISABLE} = 4'b1000 >> k[1:0];
		@(posedge MCLK);
		#1;
		an = {REG_ACK, REG_NACK};
		q = REG_RDATA;
		// Released lines show the inverse so stale values never look valid.
		// One idle edge follows, so a next call never raises a strobe in the step that lowered it.
		{REG_WR, REG_RD, HV_ENABLE, HV_DISABLE} = 4'h0;
		REG_ADDR = ~a;
		REG_WDATA = ~d;
		@(posedge MCLK);
		#1;
	endtask
endmodule

/* File: tb/tb_dcr_reg_bank.sv */
// Self-checking bench of the DAC register bank driven through the host model.
`timescale 1ns/10ps
module tb_dcr_reg_bank;
	import dcr_pkg::*;
	localparam logic [1:0] ok_a = 2'b10;
	localparam logic [1:0] no_a = 2'b01;
	logic mclk = 0;
	logic resetn = 0;
	logic hv_pin = 0;
	logic a_lo = 0;
	logic a_hi = 1;
	logic por = 0;
	logic [4:0] addr, a;
	logic [15:0] wdata, rdata, ref_sel, pd_sel, q, v, d, e;
	logic wr, rd_s, hv_en, hv_dis, ack, nack, vref, busy;
	logic [127:0] code;
	logic [127:0] code4;
	logic [15:0] rdata4;
	logic [6:0] saddr4;
	logic [7:0] gain;
	logic [6:0] saddr;
	logic [1:0] an, lk;
	logic [15:0] cl [8];
	logic [15:0] cs [8];
	logic [15:0] ex [4];
	logic [15:0] pdl = 0;
	logic [15:0] pds = 0;
	logic [4:0] res [4] = '{5'h0c, 5'h0f, 5'h1b, 5'h1f};
	int seed = 32'h4beb;
	int bad_count = 0;
	int n_tests = 0;
	int c;

	// Free-running 200 MHz clock.
	always #2.5 mclk = ~mclk;

	dcr_reg_bank #(.NV_WRITE_CYCLES(4)) i_dcr_reg_bank (.MCLK(mclk), .RESETN(resetn), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd_s), .HV_ENABLE(hv_en), .HV_DISABLE(hv_dis),
		.HIGH_VOLTAGE_COMMAND_PIN(hv_pin), .ADDRESS_SELECT_PIN_LOW(a_lo), .ADDRESS_SELECT_PIN_HIGH(a_hi),
		.POR_EVENT(por), .REG_RDATA(rdata), .REG_ACK(ack), .REG_NACK(nack), .CODE_OUT(code),
		.REF_SELECT(ref_sel), .POWERDOWN_SELECT(pd_sel), .GAIN_OUT(gain), .VREF_DRIVE(vref),
		.EEPROM_BUSY_FLAG(busy), .SLAVE_ADDRESS(saddr));

	// A quad, 8-bit, volatile-only part shares the bus; only its outputs are checked, the host follows the first.
	dcr_reg_bank #(.CHANNELS(4), .CODE_BITS(8), .HAS_NV(1'b0), .NV_WRITE_CYCLES(4)) i_dcr_reg_bank_quad (
		.MCLK(mclk), .RESETN(resetn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd_s),
		.HV_ENABLE(hv_en), .HV_DISABLE(hv_dis), .HIGH_VOLTAGE_COMMAND_PIN(hv_pin), .ADDRESS_SELECT_PIN_LOW(a_lo),
		.ADDRESS_SELECT_PIN_HIGH(a_hi), .POR_EVENT(por), .REG_RDATA(rdata4), .REG_ACK(), .REG_NACK(),
		.CODE_OUT(code4), .REF_SELECT(), .POWERDOWN_SELECT(), .GAIN_OUT(), .VREF_DRIVE(), .EEPROM_BUSY_FLAG(),
		.SLAVE_ADDRESS(saddr4));

	dcr_host i_dcr_host (.MCLK(mclk), .EEPROM_BUSY_FLAG(busy), .REG_ACK(ack), .REG_NACK(nack),
		.REG_RDATA(rdata), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd_s),
		.HV_ENABLE(hv_en), .HV_DISABLE(hv_dis));

	// Compares a data word or flag.
	task automatic chk16(input logic [15:0] g, input logic [15:0] x, input string m);
		n_tests++;
		if (g !== x) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, x);
		end
	endtask

	// Compares an acknowledge pair.
	task automatic chk_ans(input logic [1:0] g, input logic [1:0] x);
		chk16({14'h0, g}, {14'h0, x}, "answer");
	endtask

	task automatic run(input logic [2:0] k, input logic [4:0] ad, input logic [15:0] dd, input logic [1:0] ea);
		i_dcr_host.cmd(k, ad, dd, an, q);
		chk_ans(an, ea);
	endtask

	// All-ones data is only expected from reserved places, which refuse.
	task automatic rd(input logic [4:0] ad, input logic [15:0] x);
		run(1, ad, 16'h0000, x === 16'hffff ? no_a : ok_a);
		chk16(q, x, "read");
	endtask

	// Kinds: 0 live code, 1 stored code, 2 live configuration, 3 stored configuration.
	function automatic logic [1:0] lock_ans(input logic [1:0] l, input int t);
		logic [3:0] allow;
		allow = t == 0 ? 4'b0011 : t == 2 ? 4'b0111 : 4'b0001;
		return allow[l] ? ok_a : no_a;
	endfunction

	task automatic wrap_up();
		bad_count += i_dcr_host.stuck;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Guard against a hung handshake.
	initial begin
		repeat (20000) @(posedge mclk);
		$display("unexpected at %0t: run did not finish", $time);
		bad_count++;
		wrap_up();
	end

	// Main sequence; every step starts one step after a rising edge.
	initial begin
		for (int i = 0; i < 8; i++) begin
			cl[i] = i < 2 ? 16'h07ff : 16'h0fff;
			cs[i] = cl[i];
		end
		repeat (20) @(posedge mclk);
		#1;
		resetn = 1;
		@(posedge mclk);
		#1;
		rd(5'h00, 16'h07ff);
		chk16(rdata4, 16'h007f, "quad mid scale");
		chk16(code4[47:32], 16'h00ff, "quad full scale");
		for (int i = 4; i < 8; i++) begin
			chk16(code4[16*i +: 16], 16'h0000, "quad absent code");
		end
		rd(5'h13, 16'h0fff);
		rd(OFS_REF_STORED, 16'h0000);
		rd(OFS_LOCK_STATUS, 16'h0000);
		rd(OFS_GAIN_STATUS, 16'h0080);
		rd(OFS_GAIN_STATUS, 16'h0000);
		rd(OFS_GAIN_ADDR_STORED, 16'h00e2);
		chk16({9'h0, saddr}, 16'h0062, "address");
		i_dcr_host.late = 2;
		foreach (res[i]) begin
			rd(res[i], 16'hffff);
		end
		run(0, 5'h1d, 16'h0001, no_a);
		i_dcr_host.late = 0;
		// Random codes back to back, the first with every upper bit set.
		for (int i = 0; i < 8; i++) begin
			c = $random(seed) & 7;
			v = i == 0 ? 16'hffff : 16'($random(seed));
			run(0, 5'(c), v, ok_a);
			cl[c] = v & 16'h0fff;
			rd(5'(c), cl[c]);
			chk16(code[16*c +: 16], cl[c], "code");
		end
		for (int r = 0; r < 4; r++) begin
			run(0, OFS_REF_LIVE, 16'(r), ok_a);
			run(0, OFS_PD_LIVE, 16'(3 - r), ok_a);
			@(posedge mclk);
			#1;
			chk16(ref_sel, 16'(r), "ref");
			chk16(pd_sel, 16'(3 - r), "pd");
			chk16({15'h0, vref}, 16'(r == 1), "vref");
		end
		run(0, OFS_GAIN_STATUS, 16'ha5ff, ok_a);
		rd(OFS_GAIN_STATUS, 16'ha500);
		chk16(rdata4, 16'h0500, "quad gain");
		chk16({8'h0, gain}, 16'h00a5, "gain");
		// Walk one channel through every lock code, ending unlocked.
		hv_pin = 1;
		run(2, OFS_REF_LIVE, 16'h0000, no_a);
		c = $random(seed) & 7;
		for (int k = 3; k >= 0; k--) begin
			lk = 2'(k);
			run(lk[1] ? 3'd2 : 3'd3, 5'h10 | 5'(c), 16'h0000, ok_a);
			run(lk[0] ? 3'd2 : 3'd3, 5'(c), 16'h0000, ok_a);
			rd(OFS_LOCK_STATUS, 16'(lk) << (2 * c));
			v = 16'($random(seed)) & 16'h0fff;
			ex = '{cl[c], cs[c], pdl, pds};
			for (int t = 0; t < 4; t++) begin
				a = t == 0 ? 5'(c) : t == 1 ? 5'h10 | 5'(c) : t == 2 ? OFS_PD_LIVE : OFS_PD_STORED;
				d = t < 2 ? v : ex[t] ^ (16'h0003 << (2 * c));
				run(0, a, d, lock_ans(lk, t));
				if (lock_ans(lk, t) == ok_a) begin
					ex[t] = d;
				end
				rd(a, ex[t]);
			end
			cl[c] = ex[0];
			cs[c] = ex[1];
			pdl = ex[2];
			pds = ex[3];
		end
		hv_pin = 0;
		run(2, 5'(c), 16'h0000, no_a);
		rd(OFS_LOCK_STATUS, 16'h0000);
		// Stored write, then a refused stored access and an accepted live one while busy.
		v = 16'h0abc;
		run(0, OFS_CODE_STORED0, v, ok_a);
		cs[0] = v;
		chk16({15'h0, busy}, 16'h0001, "busy");
		run(4, 5'h11, v, no_a);
		run(0, 5'h01, 16'h0123, ok_a);
		cl[1] = 16'h0123;
		rd(OFS_CODE_STORED0, v);
		rd(5'h00, cl[0]);
		por = 1;
		@(posedge mclk);
		#1;
		por = 0;
		for (int i = 0; i < 8; i++) begin
			rd(5'(i), cs[i]);
		end
		rd(OFS_PD_LIVE, pds);
		rd(OFS_GAIN_STATUS, 16'h0080);
		run(0, OFS_GAIN_ADDR_STORED, 16'h0040, no_a);
		hv_pin = 1;
		run(3, OFS_GAIN_ADDR_STORED, 16'h0000, ok_a);
		rd(OFS_GAIN_ADDR_STORED, 16'h0062);
		run(0, OFS_GAIN_ADDR_STORED, 16'h0040, ok_a);
		a_lo = 1;
		rd(OFS_GAIN_ADDR_STORED, 16'h0043);
		chk16({9'h0, saddr}, 16'h0043, "address");
		chk16({9'h0, saddr4}, 16'h0063, "fixed address");
		wrap_up();
	end
endmodule
